//--- pkg/low_supply_monitor_defines.svh
`ifndef LOW_SUPPLY_MONITOR_DEFINES_SVH
`define LOW_SUPPLY_MONITOR_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets, taken from haddr[7:0]
// ----------------------------------------------------------------
`define STATUS_OFS      8'h00
`define CONFIG_OFS      8'h04
`define TRIP_OFS        8'h08

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FLAG_BIT        0
`define PWRD_BIT        0
`define RSTD_BIT        1
`define STOPEN_BIT      2
`define TRIP_BIT        0
`define TRIP_DONE_BIT   1

// ----------------------------------------------------------------
// reset values and bus codes
// ----------------------------------------------------------------
`define CONFIG_RST      3'h0
`define TRIP_RST        1'h0
`define HTRANS_NONSEQ   2'h2
`define HRESP_OKAY      1'h0

`endif

//--- pkg/low_supply_monitor_pkg.sv
package low_supply_monitor_pkg;

   // comparator results, falling and rising threshold
   typedef struct packed {
      logic below_falling;
      logic above_rising;
   } cmp_s;

   // software settings from the configuration register
   typedef struct packed {
      logic stop_enable;
      logic reset_disable;
      logic power_disable;
   } cfg_s;

   // latched address phase of an ahb write
   typedef struct packed {
      logic       valid;
      logic [7:0] addr;
   } wr_phase_s;

   // low-supply reset guard
   typedef enum logic [0:0] {
      guard_watch = 1'b0,
      guard_hold  = 1'b1
   } guard_e;

endpackage : low_supply_monitor_pkg

//--- verilog/low_supply_monitor_control.sv
// What this block does
// (R1) trip range clear after power-on reset
// (R2) low-supply reset held until above rising threshold
// (R3) monitor enabled by default out of reset
// (R4) power-disable stops resets and flag updates
// (R5) reset-disable suppresses every low-supply reset
// (R6) stop mode active only if enabled, powered
// (R7) trip range set selects higher supply range
// (R8) enabled monitor resets chip below falling threshold
// (R9) software polls flag with resets disabled
// (R10) trip range accepts one write only
// (R11) no interrupt request is ever raised
// (R12) active in wait, reset wakes from wait
// (R13) active in stop, reset wakes from stop
// (R14) flag sets below falling, clears above rising
// (R15) comparator results pass two flip-flops
// (R16) settings come from the configuration register
`include "low_supply_monitor_defines.svh"
`timescale 1ns/1ps

module low_supply_monitor_control
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        reset,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // analog comparator, asynchronous
   input  wire logic        cmp_below_falling,
   input  wire logic        cmp_above_rising,
   output logic             trip_range_select,
   output logic             monitor_power_on,
   // system integration
   input  wire logic        wait_mode,
   input  wire logic        stop_mode,
   output logic             low_supply_reset_req,
   output logic             low_power_wake_req
);

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   function automatic logic [31:0] read_word
   (
      input logic [7:0]                 addr,
      input logic                       flag,
      input low_supply_monitor_pkg::cfg_s cfg,
      input logic                       trip,
      input logic                       done
   );
      logic [31:0] word;
      word = 32'h0000_0000;
      if (addr == `STATUS_OFS)
         word[`FLAG_BIT] = flag;
      else if (addr == `CONFIG_OFS)
      begin
         word[`PWRD_BIT]   = cfg.power_disable;
         word[`RSTD_BIT]   = cfg.reset_disable;
         word[`STOPEN_BIT] = cfg.stop_enable;
      end
      else if (addr == `TRIP_OFS)
      begin
         word[`TRIP_BIT]      = trip;
         word[`TRIP_DONE_BIT] = done;
      end
      return word;
   endfunction : read_word

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   low_supply_monitor_pkg::cmp_s      cmp_meta;
   low_supply_monitor_pkg::cmp_s      cmp_sync;
   low_supply_monitor_pkg::cfg_s      cfg;
   low_supply_monitor_pkg::cfg_s      next_cfg;
   low_supply_monitor_pkg::wr_phase_s wr_phase;
   low_supply_monitor_pkg::guard_e    guard;
   low_supply_monitor_pkg::guard_e    next_guard;
   logic                              trip;
   logic                              next_trip;
   logic                              trip_done;
   logic                              next_trip_done;
   logic                              flag;
   logic                              next_flag;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   wire addr_phase = hsel & hready & (htrans == `HTRANS_NONSEQ);
   wire wr_start   = addr_phase & hwrite;
   wire rd_start   = addr_phase & ~hwrite;
   wire wr_config  = wr_phase.valid & (wr_phase.addr == `CONFIG_OFS);
   wire wr_trip    = wr_phase.valid & (wr_phase.addr == `TRIP_OFS);

   // zero wait states, always okay; hsize is whole word only
   assign hreadyout = 1'b1;
   assign hresp     = `HRESP_OKAY;

   // ----------------------------------------------------------------
   // settings
   // ----------------------------------------------------------------
   // R16
   assign next_cfg.power_disable = wr_config ? hwdata[`PWRD_BIT]   : cfg.power_disable;
   assign next_cfg.reset_disable = wr_config ? hwdata[`RSTD_BIT]   : cfg.reset_disable;
   assign next_cfg.stop_enable   = wr_config ? hwdata[`STOPEN_BIT] : cfg.stop_enable;

   // later writes are dropped so the protection range cannot move
   wire trip_take = wr_trip & ~trip_done; // R10
   assign next_trip      = trip_take ? hwdata[`TRIP_BIT] : trip;
   assign next_trip_done = trip_done | wr_trip;

   // R7
   assign trip_range_select = trip;

   // ----------------------------------------------------------------
   // monitor activity
   // ----------------------------------------------------------------
   // wait mode leaves the monitor running; stop needs the enable
   wire monitor_active = ~cfg.power_disable
                         & (~stop_mode | cfg.stop_enable); // R4 R6 R12
   wire reset_enable   = monitor_active & ~cfg.reset_disable; // R5

   // analog side is powered from reset onward unless disabled, or in stop mode without the stop enable
   assign monitor_power_on = monitor_active; // R3

   // ----------------------------------------------------------------
   // comparator settling
   // ----------------------------------------------------------------
   // a freshly powered comparator leaves stale results in the two sync
   // stages; they are ignored until two edges of activity have passed
   logic [1:0] active_age;
   wire        cmp_valid   = monitor_active & (&active_age); // R15
   wire        reset_armed = reset_enable & cmp_valid; // R8

   // ----------------------------------------------------------------
   // status flag with hysteresis
   // ----------------------------------------------------------------
   // falling wins if both comparators report at once
   assign next_flag = ~cmp_valid              ? flag :
                      cmp_sync.below_falling  ? 1'b1 :
                      cmp_sync.above_rising   ? 1'b0 : flag; // R14

   // ----------------------------------------------------------------
   // low-supply reset guard
   // ----------------------------------------------------------------
   always_comb
   begin
      next_guard = guard;
      unique case (guard)
         low_supply_monitor_pkg::guard_watch:
            if (reset_armed & cmp_sync.below_falling)
               next_guard = low_supply_monitor_pkg::guard_hold; // R8
         low_supply_monitor_pkg::guard_hold:
            // released only above the rising threshold or when disabled
            if (cmp_sync.above_rising | ~reset_enable)
               next_guard = low_supply_monitor_pkg::guard_watch; // R2
      endcase
   end

   // no interrupt output exists; reset and flag are the only results
   assign low_supply_reset_req = (guard == low_supply_monitor_pkg::guard_hold); // R11
   assign low_power_wake_req   = low_supply_reset_req
                                 & (wait_mode | stop_mode); // R12 R13

   // ----------------------------------------------------------------
   // flip-flops
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         cmp_meta   <= '0;
         cmp_sync   <= '0;
         active_age <= 2'h0;
      end
      else
      begin
         cmp_meta   <= {cmp_below_falling, cmp_above_rising}; // R15
         cmp_sync   <= cmp_meta;
         active_age <= {active_age[0], monitor_active};
      end
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         cfg       <= `CONFIG_RST;
         trip      <= `TRIP_RST; // R1
         trip_done <= 1'b0;
         flag      <= 1'b0;
         guard     <= low_supply_monitor_pkg::guard_watch;
      end
      else
      begin
         cfg       <= next_cfg;
         trip      <= next_trip;
         trip_done <= next_trip_done;
         flag      <= next_flag;
         guard     <= next_guard;
      end
   end

   // read data forwards same-edge writes so back-to-back reads are fresh
   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         wr_phase <= '0;
         hrdata   <= 32'h0000_0000;
      end
      else
      begin
         wr_phase <= '{valid: wr_start, addr: haddr[7:0]};
         if (rd_start)
            hrdata <= read_word(haddr[7:0], next_flag, next_cfg,
                                next_trip, next_trip_done);
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   flag_set_a: assert property (@(posedge clk_sys) disable iff (reset) // R14
      cmp_valid && cmp_sync.below_falling |=> flag)
      else $error("flag did not set below falling threshold");

   flag_clear_a: assert property (@(posedge clk_sys) disable iff (reset) // R14
      cmp_valid && cmp_sync.above_rising && !cmp_sync.below_falling |=> !flag)
      else $error("flag did not clear above rising threshold");

   flag_hold_a: assert property (@(posedge clk_sys) disable iff (reset) // R4
      !monitor_active |=> $stable(flag))
      else $error("flag moved while monitor inactive");

   sync_delay_a: assert property (@(posedge clk_sys) disable iff (reset) // R15
      ##2 cmp_sync.below_falling == $past(cmp_below_falling, 2))
      else $error("comparator not delayed by two stages");

   reset_fire_a: assert property (@(posedge clk_sys) disable iff (reset) // R8
      reset_armed && cmp_sync.below_falling |=> low_supply_reset_req)
      else $error("no reset below falling threshold");

   reset_hold_a: assert property (@(posedge clk_sys) disable iff (reset) // R2
      low_supply_reset_req && !cmp_sync.above_rising && reset_enable
      |=> low_supply_reset_req)
      else $error("reset released before rising threshold");

   rstd_quiet_a: assert property (@(posedge clk_sys) disable iff (reset) // R5
      cfg.reset_disable [*2] |-> !low_supply_reset_req)
      else $error("reset issued while reset disabled");

   pwrd_quiet_a: assert property (@(posedge clk_sys) disable iff (reset) // R4
      cfg.power_disable [*2] |-> !low_supply_reset_req && !monitor_power_on)
      else $error("monitor working while power disabled");

   stop_idle_a: assert property (@(posedge clk_sys) disable iff (reset) // R6
      stop_mode && !cfg.stop_enable |-> !monitor_active)
      else $error("monitor active in stop without enable");

   trip_once_a: assert property (@(posedge clk_sys) disable iff (reset) // R10
      trip_done |=> $stable(trip_range_select) && trip_done)
      else $error("trip range changed after first write");

   wake_a: assert property (@(posedge clk_sys) disable iff (reset) // R13
      low_supply_reset_req && stop_mode |-> low_power_wake_req)
      else $error("reset did not wake from stop");

   wait_wake_a: assert property (@(posedge clk_sys) disable iff (reset) // R12
      low_supply_reset_req && wait_mode |-> low_power_wake_req)
      else $error("reset did not wake from wait");

   wake_quiet_a: assert property (@(posedge clk_sys) disable iff (reset) // R12
      !low_supply_reset_req |-> !low_power_wake_req)
      else $error("wake requested without a reset");

   inactive_quiet_a: assert property (@(posedge clk_sys) disable iff (reset) // R4
      !monitor_active |=> !low_supply_reset_req)
      else $error("reset kept while monitor inactive");

   hold_release_a: assert property (@(posedge clk_sys) disable iff (reset) // R2
      low_supply_reset_req && !reset_enable |=> !low_supply_reset_req)
      else $error("reset kept after resets were disabled");

   settle_gate_a: assert property (@(posedge clk_sys) disable iff (reset) // R15
      !monitor_active |=> !cmp_valid)
      else $error("stale comparator result used after power up");

   stop_active_a: assert property (@(posedge clk_sys) disable iff (reset) // R6
      stop_mode && cfg.stop_enable && !cfg.power_disable |-> monitor_active)
      else $error("monitor inactive in stop despite enable");

   wait_active_a: assert property (@(posedge clk_sys) disable iff (reset) // R12
      wait_mode && !stop_mode && !cfg.power_disable |-> monitor_active)
      else $error("monitor inactive in wait mode");

   range_default_a: assert property (@(posedge clk_sys) disable iff (reset) // R1
      !trip_done |-> !trip_range_select)
      else $error("trip range left lower range before a write");

   trip_lock_a: assert property (@(posedge clk_sys) disable iff (reset) // R10
      wr_trip |=> trip_done)
      else $error("trip range not locked by its first write");

   flag_between_a: assert property (@(posedge clk_sys) disable iff (reset) // R14
      cmp_valid && !cmp_sync.below_falling && !cmp_sync.above_rising |=> $stable(flag))
      else $error("flag moved between thresholds");

   // ----------------------------------------------------------------
   // coverage
   // ----------------------------------------------------------------
   wait_wake_c: cover property (@(posedge clk_sys) disable iff (reset)
      wait_mode && low_power_wake_req);

   reset_seen_c: cover property (@(posedge clk_sys) disable iff (reset)
      !low_supply_reset_req ##1 low_supply_reset_req ##[1:20] !low_supply_reset_req);

   polled_flag_c: cover property (@(posedge clk_sys) disable iff (reset)
      cfg.reset_disable && !cfg.power_disable && $rose(flag));

   trip_retry_c: cover property (@(posedge clk_sys) disable iff (reset)
      trip_done && wr_trip);

   stop_wake_c: cover property (@(posedge clk_sys) disable iff (reset)
      stop_mode && low_power_wake_req);

endmodule : low_supply_monitor_control

//--- tb/supply_comparator_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// supply comparator stand-in with two trip ranges
// ----------------------------------------------------------------
module supply_comparator_model
#(
   parameter logic [7:0] LOW_FALL  = 8'h18,
   parameter logic [7:0] LOW_RISE  = 8'h1a,
   parameter logic [7:0] HIGH_FALL = 8'h28,
   parameter logic [7:0] HIGH_RISE = 8'h2a
)
(
   // supply level and control
   input  wire logic [7:0] vdd_level,
   input  wire logic       range_high,
   input  wire logic       powered,
   // comparator results
   output logic            below_falling,
   output logic            above_rising
);
   wire logic [7:0] fall_level = range_high ? HIGH_FALL : LOW_FALL;
   wire logic [7:0] rise_level = range_high ? HIGH_RISE : LOW_RISE;
   wire logic       is_below   = vdd_level < fall_level;
   wire logic       is_above   = vdd_level > rise_level;
   // unpowered comparator is untrustworthy: report the opposite verdict
   assign below_falling = powered ? is_below : is_above;
   assign above_rising  = powered ? is_above : is_below;
endmodule : supply_comparator_model

//--- tb/tb_top.sv
`include "low_supply_monitor_defines.svh"
`timescale 1ns/1ps

module tb_top;
   logic        clk_sys, reset, hsel, hwrite, wait_mode, stop_mode;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic        hreadyout, hresp, below, above, trip, pwr_on, rst_req, wake;
   logic [7:0]  vdd;
   int          fail_count, n_compared;

   // ----------------------------------------------------------------
   // design and comparator stand-in
   // ----------------------------------------------------------------
   low_supply_monitor_control uut (.clk_sys(clk_sys), .reset(reset), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .cmp_below_falling(below), .cmp_above_rising(above), .trip_range_select(trip),
      .monitor_power_on(pwr_on), .wait_mode(wait_mode), .stop_mode(stop_mode),
      .low_supply_reset_req(rst_req), .low_power_wake_req(wake));
   supply_comparator_model cmp (.vdd_level(vdd), .range_high(trip), .powered(pwr_on),
      .below_falling(below), .above_rising(above));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task summarize;
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("ERROR at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask : chk

   // hreadyout is sampled, never assumed; a stuck bus ends the run
   task wait_ready;
      for (int i = 0; i < 20; i++)
      begin
         @(posedge clk_sys);
         if (hreadyout === 1'b1)
            return;
      end
      fail_count++;
      $display("ERROR at %0t: bus never ready", $time);
      summarize();
   endtask : wait_ready

   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel   <= 1'b1;
      htrans <= `HTRANS_NONSEQ;
      haddr  <= {24'h000000, a};
      hwrite <= wr;
      wait_ready();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
   endtask : xfer

   task rd(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h00000000);
      chk(hrdata, exp);
   endtask : rd

   // comparator results need three edges to reach the flag and the request
   task step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : step

   // ----------------------------------------------------------------
   // clock and main sequence
   // ----------------------------------------------------------------
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   initial
   begin
      reset = 1'b1; hsel = 1'b0; hwrite = 1'b0; haddr = 32'h0; hwdata = 32'h0;
      htrans = 2'h0; wait_mode = 1'b0; stop_mode = 1'b0; vdd = 8'h1e;
      fail_count = 0; n_compared = 0;
      repeat (6) @(posedge clk_sys);
      reset <= 1'b0;
      step(1);
      chk(trip, 32'h0);
      chk(pwr_on, 32'h1);
      rd(`TRIP_OFS, 32'h0);
      rd(`CONFIG_OFS, 32'h0);
      rd(8'h0c, 32'h0);
      rd(`STATUS_OFS, 32'h0);
      // forced reset with hysteresis, wake from wait
      vdd <= 8'h14;
      step(4);
      chk(rst_req, 32'h1);
      rd(`STATUS_OFS, 32'h1);
      wait_mode <= 1'b1;
      step(1);
      chk(wake, 32'h1);
      wait_mode <= 1'b0;
      vdd <= 8'h19;
      step(4);
      chk(rst_req, 32'h1);
      rd(`STATUS_OFS, 32'h1);
      vdd <= 8'h1e;
      step(4);
      chk(rst_req, 32'h0);
      rd(`STATUS_OFS, 32'h0);
      // stop mode
      xfer(1'b1, `CONFIG_OFS, 32'h4);
      stop_mode <= 1'b1;
      step(1);
      chk(pwr_on, 32'h1);
      vdd <= 8'h14;
      step(4);
      chk(wake, 32'h1);
      vdd <= 8'h1e;
      step(4);
      xfer(1'b1, `CONFIG_OFS, 32'h5);
      step(1);
      chk(pwr_on, 32'h0);
      xfer(1'b1, `CONFIG_OFS, 32'h0);
      step(1);
      chk(pwr_on, 32'h0);
      stop_mode <= 1'b0;
      // polled use, then monitor switched off
      xfer(1'b1, `CONFIG_OFS, 32'h2);
      rd(`CONFIG_OFS, 32'h2);
      vdd <= 8'h14;
      step(4);
      chk(rst_req, 32'h0);
      rd(`STATUS_OFS, 32'h1);
      xfer(1'b1, `CONFIG_OFS, 32'h3);
      vdd <= 8'h1e;
      step(4);
      rd(`STATUS_OFS, 32'h1);
      chk(rst_req, 32'h0);
      xfer(1'b1, `CONFIG_OFS, 32'h0);
      step(4);
      rd(`STATUS_OFS, 32'h0);
      // one-shot trip range; the mid supply is now under the higher threshold
      xfer(1'b1, `TRIP_OFS, 32'h1);
      rd(`TRIP_OFS, 32'h3);
      chk(trip, 32'h1);
      xfer(1'b1, `TRIP_OFS, 32'h0);
      rd(`TRIP_OFS, 32'h3);
      step(4);
      chk(rst_req, 32'h1);
      vdd <= 8'h32;
      step(4);
      chk(rst_req, 32'h0);
      chk(hresp, 32'h0);
      chk(hreadyout, 32'h1);
      chk(wake, 32'h0);
      summarize();
   end
endmodule : tb_top
